// ==== design/spierr_top.v ====
// Purpose: Serial peripheral master/slave core keeping the documented defect behaviour
// Assumes: Serial pins synchronous to i_clock
// Notes: Plain ports stand in for configuration and status registers
//
// Contract
// - In slave mode a lost transmit character is never reported.
// - With mixed divider fields of one across chip selects, polarity one and phase bit zero, an extra clock pulse is emitted when the chip select changes.
// - In slave mode the receive-ready flag may rise falsely at enable or during the first transfer.
// - After that start-up sequence the receive-ready flag follows real reception.
`timescale 1ns/10ps
`include "spierr_map.vh"
module spierr_top (
    input wire i_clock,
    input wire i_reset,
    input wire i_enable,
    input wire i_master,
    input wire i_clock_polarity_bit,
    input wire i_clock_phase_bit,
    input wire [1:0] i_cs_select,
    input wire [31:0] i_clock_divider_field,
    input wire i_tx_valid,
    input wire [7:0] i_tx_data,
    input wire i_rx_read,
    input wire i_sck_in,
    input wire i_mosi_in,
    input wire i_miso_in,
    input wire i_ss_n,
    output reg o_sck_q,
    output reg o_mosi_q,
    output reg o_miso_q,
    output reg o_miso_oe_q,
    output reg [3:0] o_cs_n_q,
    output reg [7:0] o_receive_holding_reg_q,
    output reg o_receive_ready_flag_q,
    output reg o_tx_empty_q,
    output reg o_busy_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_EXTRA = 2'h2;

    wire [3:0] fast;
    genvar g;
    generate
        for (g = 0; g < `SPIERR_NUM_CS; g = g + 1) begin : g_div
            spierr_clkdiv u_div (
                .i_div(i_clock_divider_field[g*8 +: 8]),
                .o_fast(fast[g])
            );
        end
    endgenerate

    // Mixed fast/slow dividers under this mode give the spurious pulse
    wire mixed = (|fast) && !(&fast) && i_clock_polarity_bit && !i_clock_phase_bit;

    reg [1:0] state_q;
    reg [7:0] cnt_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg sck_prev_q;
    reg ss_prev_q;
    reg pol_prev_q;
    reg en_prev_q;
    reg first_q;
    reg glitch_q;
    reg [1:0] last_cs_q;
    wire [7:0] div_sel = i_clock_divider_field[i_cs_select*8 +: 8];
    wire idle_lvl = i_clock_polarity_bit;
    wire s_edge = i_sck_in ^ sck_prev_q;
    wire s_lead = s_edge && (i_sck_in != idle_lvl);
    wire s_trail = s_edge && (i_sck_in == idle_lvl);
    wire s_sample = i_clock_phase_bit ? s_lead : s_trail;
    wire s_shift = i_clock_phase_bit ? s_trail : s_lead;
    wire pol_change = i_clock_polarity_bit != pol_prev_q;
    wire rx_done_slv = i_enable && !i_master && !i_ss_n && s_sample && (bit_q == 4'h7);
    // Done on the last count after the closing edge; the half-period counter never reaches zero
    wire rx_done_mst = i_enable && i_master && (state_q == ST_SHIFT) && (cnt_q <= 8'h01)
        && (o_sck_q == idle_lvl) && (bit_q == 4'h8);
    // False flag fires on the first edge of the first frame when not cleared
    wire glitch_fire = i_enable && !i_master && glitch_q && first_q && s_edge && !i_ss_n;
    reg flag_d;
    reg [7:0] hold_d;
    reg glitch_d;
    reg first_d;

    // Stale glitch armed at enable; only a polarity toggle in slave mode disarms it
    always @* begin
        glitch_d = glitch_q;
        first_d = first_q;
        if (i_enable && !en_prev_q && !i_master) begin
            glitch_d = 1'b1;
            first_d = 1'b1;
        end else if (pol_change && !i_master) begin
            glitch_d = 1'b0;
            first_d = 1'b0;
        end
        if (glitch_fire) first_d = 1'b0;
    end

    // Set beats clear, so a byte finishing on a read is not lost
    always @* begin
        flag_d = o_receive_ready_flag_q;
        hold_d = o_receive_holding_reg_q;
        if (glitch_fire) begin
            flag_d = 1'b1;
        end else if (i_rx_read) begin
            flag_d = 1'b0;
        end
        if (rx_done_slv) begin
            hold_d = {shift_q[6:0], i_mosi_in};
            flag_d = 1'b1;
        end else if (rx_done_mst) begin
            hold_d = shift_q;
            flag_d = 1'b1;
        end
    end

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
            pol_prev_q <= 1'b0;
            en_prev_q <= 1'b0;
            first_q <= 1'b0;
            glitch_q <= 1'b0;
            last_cs_q <= 2'h0;
            o_sck_q <= 1'b0;
            o_mosi_q <= 1'b0;
            o_miso_q <= 1'b0;
            o_miso_oe_q <= 1'b0;
            o_cs_n_q <= 4'hf;
            o_receive_holding_reg_q <= 8'h00;
            o_receive_ready_flag_q <= 1'b0;
            o_tx_empty_q <= 1'b1;
            o_busy_q <= 1'b0;
        end else begin
            sck_prev_q <= i_sck_in;
            ss_prev_q <= i_ss_n;
            pol_prev_q <= i_clock_polarity_bit;
            en_prev_q <= i_enable;
            o_busy_q <= (state_q != ST_IDLE) || (!i_master && !i_ss_n);
            if (i_tx_valid && i_enable && o_tx_empty_q) begin
                tx_q <= i_tx_data;
                o_tx_empty_q <= 1'b0;
            end
            glitch_q <= glitch_d;
            first_q <= first_d;
            if (!i_enable) begin
                state_q <= ST_IDLE;
                o_cs_n_q <= 4'hf;
                o_sck_q <= idle_lvl;
                o_miso_oe_q <= 1'b0;
                bit_q <= 4'h0;
            end else if (!i_master) begin
                o_sck_q <= idle_lvl;
                o_miso_oe_q <= !i_ss_n;
                if (i_ss_n) begin
                    bit_q <= 4'h0;
                    // No underrun flag: an empty transmitter just resends old data
                    if (ss_prev_q == 1'b0) o_tx_empty_q <= 1'b1;
                end else begin
                    // First bit must stand before the first clock edge in either phase
                    if (ss_prev_q) o_miso_q <= tx_q[7];
                    if (s_sample) begin
                        shift_q <= {shift_q[6:0], i_mosi_in};
                        bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
                    end
                    if (s_shift) o_miso_q <= tx_q[3'h7 - bit_q[2:0]];
                end
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        o_sck_q <= idle_lvl;
                        if (!o_tx_empty_q) begin
                            o_cs_n_q <= ~(4'h1 << i_cs_select);
                            o_mosi_q <= tx_q[7];
                            shift_q <= tx_q;
                            cnt_q <= div_sel;
                            bit_q <= 4'h0;
                            o_tx_empty_q <= 1'b1;
                            // Switching to any other select than the last one while mixed emits a pulse
                            state_q <= (mixed && last_cs_q != i_cs_select) ? ST_EXTRA : ST_SHIFT;
                            last_cs_q <= i_cs_select;
                        end
                    end
                    ST_EXTRA: begin
                        o_sck_q <= ~o_sck_q;
                        if (o_sck_q != idle_lvl) state_q <= ST_SHIFT;
                    end
                    ST_SHIFT: begin
                        if (cnt_q > 8'h01) begin
                            cnt_q <= cnt_q - 8'h01;
                        end else if (bit_q == 4'h8) begin
                            state_q <= ST_IDLE;
                            o_cs_n_q <= 4'hf;
                        end else begin
                            cnt_q <= div_sel;
                            o_sck_q <= ~o_sck_q;
                            if (o_sck_q == idle_lvl) begin
                                shift_q <= {shift_q[6:0], i_miso_in};
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                o_mosi_q <= shift_q[7];
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
            o_receive_holding_reg_q <= hold_d;
            o_receive_ready_flag_q <= flag_d;
        end
    end
endmodule

// ==== design/spierr_map.vh ====
// Purpose: Constants for the serial peripheral defect-behaviour block
// Assumes: 100 MHz clock
// Notes: Divider field is eight bits wide
`ifndef SPIERR_MAP_VH
`define SPIERR_MAP_VH
`define SPIERR_DIV_W 8
`define SPIERR_NUM_CS 4
`define SPIERR_DIV_FAST 8'h01
`define SPIERR_RESET_DIV 8'h01
`define SPIERR_DATA_W 8
`endif

// ==== design/spierr_clkdiv.v ====
// Purpose: Per-chip-select divider compare
// Assumes: Synchronous inputs
// Notes: Flags a divider field of one
`timescale 1ns/10ps
`include "spierr_map.vh"
module spierr_clkdiv (
    input wire [7:0] i_div,
    output wire o_fast
);
    assign o_fast = (i_div == `SPIERR_DIV_FAST);
endmodule

// ==== sim/spierr_checker_assertions.sv ====
// Purpose: Port-level checks on the defect-behaviour core
// Assumes: Single clock, async high reset
// Notes: Extra clock pulse is counted by the bench instead
`timescale 1ns/10ps
module spierr_checker (
    input wire i_clock,
    input wire i_reset,
    input wire i_enable,
    input wire i_master,
    input wire i_tx_valid,
    input wire i_rx_read,
    input wire i_ss_n,
    input wire [3:0] o_cs_n_q,
    input wire o_receive_ready_flag_q,
    input wire o_tx_empty_q,
    input wire o_busy_q,
    input wire o_miso_oe_q
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    read_clears_flag_a: assert property (i_master && i_rx_read && !o_busy_q && o_cs_n_q == 4'hF
        |=> !o_receive_ready_flag_q) else $error("ready flag not cleared by read");
    flag_stands_a: assert property (o_receive_ready_flag_q && !i_rx_read |=> o_receive_ready_flag_q)
        else $error("ready flag dropped without read");
    no_underrun_a: assert property (!i_master && !i_tx_valid && o_tx_empty_q |=> o_tx_empty_q)
        else $error("slave underrun left a trace");
    quiet_slave_a: assert property (!i_master && i_ss_n && !o_receive_ready_flag_q
        |=> !o_receive_ready_flag_q) else $error("ready flag rose while deselected");
    slave_rise_cause_a: assert property ($rose(o_receive_ready_flag_q) && !i_master |-> !$past(i_ss_n))
        else $error("slave ready flag rose outside a frame");
    miso_drive_a: assert property (!i_master && i_enable |=> o_miso_oe_q == !$past(i_ss_n))
        else $error("slave data enable does not follow select");
    cover property (!i_master && $rose(o_receive_ready_flag_q));
    cover property (i_master && $fell(o_busy_q));
    cover property (i_rx_read && o_receive_ready_flag_q);
endmodule
bind spierr_top spierr_checker u_chk (.i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
    .i_master(i_master), .i_tx_valid(i_tx_valid), .i_rx_read(i_rx_read), .i_ss_n(i_ss_n), .o_cs_n_q(o_cs_n_q),
    .o_receive_ready_flag_q(o_receive_ready_flag_q), .o_tx_empty_q(o_tx_empty_q), .o_busy_q(o_busy_q),
    .o_miso_oe_q(o_miso_oe_q));

// ==== sim/spierr_peer.sv ====
// Purpose: External serial master driving the slave pins
// Assumes: Leading-edge sampling, four clocks per half period
// Notes: Data shows the inverse of its last bit once released
`timescale 1ns/10ps
module spierr_peer (
    input wire i_clock,
    input wire i_pol,
    input wire i_miso,
    output wire o_sck,
    output reg o_mosi = 1'b0,
    output reg o_ss_n = 1'b1
);
    reg act_q = 1'b0;
    reg [7:0] rx_q = 8'h00;
    // Clock stands at idle level between frames and follows a polarity change at once
    assign o_sck = i_pol ^ act_q;
    task xfer(input [7:0] b);
        integer i;
        begin
            @(posedge i_clock) o_ss_n <= 1'b0;
            for (i = 7; i >= 0; i = i - 1) begin
                @(posedge i_clock) o_mosi <= b[i];
                repeat (3) @(posedge i_clock);
                act_q <= 1'b1;
                rx_q <= {rx_q[6:0], i_miso};
                repeat (4) @(posedge i_clock);
                act_q <= 1'b0;
            end
            repeat (4) @(posedge i_clock);
            o_ss_n <= 1'b1;
            o_mosi <= ~b[0];
        end
    endtask
endmodule

// ==== sim/spierr_tb.sv ====
// Purpose: Self-checking bench for the defect-behaviour core
// Assumes: 100 MHz clock, reset held 12 cycles
// Notes: Master data in loops back inverted from data out
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    reg i_clock = 1'b0, i_reset = 1'b1, i_enable = 1'b0, i_master = 1'b0, i_pol = 1'b0, i_pha = 1'b1;
    reg i_tx_valid = 1'b0, i_rx_read = 1'b0;
    reg [1:0] i_cs = 2'h0;
    reg [31:0] i_div = 32'h0101_0101;
    reg [7:0] i_tx_data = 8'h00;
    wire sck, mosi, miso, ss_n, o_sck_q, o_mosi_q, o_flag, o_empty, o_busy;
    wire [3:0] o_cs_n;
    wire [7:0] o_hold;
    integer n_errors = 0, comparisons = 0;
    spierr_peer u_peer (.i_clock(i_clock), .i_pol(i_pol), .i_miso(miso), .o_sck(sck), .o_mosi(mosi),
        .o_ss_n(ss_n));
    spierr_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable), .i_master(i_master),
        .i_clock_polarity_bit(i_pol), .i_clock_phase_bit(i_pha), .i_cs_select(i_cs),
        .i_clock_divider_field(i_div), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .i_rx_read(i_rx_read),
        .i_sck_in(sck), .i_mosi_in(mosi), .i_miso_in(~o_mosi_q), .i_ss_n(ss_n), .o_sck_q(o_sck_q),
        .o_mosi_q(o_mosi_q), .o_miso_q(miso), .o_miso_oe_q(), .o_cs_n_q(o_cs_n), .o_receive_holding_reg_q(o_hold),
        .o_receive_ready_flag_q(o_flag), .o_tx_empty_q(o_empty), .o_busy_q(o_busy));
    initial forever #5 i_clock = ~i_clock;
    task print_verdict;
        begin
            $display("errors=%0d comparisons=%0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task pulse_read;
        begin
            @(posedge i_clock) i_rx_read <= 1'b1;
            @(posedge i_clock) i_rx_read <= 1'b0;
            @(posedge i_clock);
        end
    endtask
    task slave_byte(input [7:0] b, input [7:0] t, input ld);
        integer k;
        begin
            if (ld) begin
                @(posedge i_clock) i_tx_data <= t;
                i_tx_valid <= 1'b1;
                @(posedge i_clock) i_tx_valid <= 1'b0;
            end
            u_peer.xfer(b);
            k = 0;
            while (o_flag !== 1'b1 && k < 100) begin @(posedge i_clock); k++; end
            if (k == 100) begin n_errors++; print_verdict; end
            `CHK(o_hold, b)
            if (ld) `CHK(u_peer.rx_q, t)
            pulse_read;
            `CHK(o_flag, 1'b0)
            `CHK(o_empty, 1'b1)
        end
    endtask
    task slave_startup;
        begin
            @(posedge i_clock) i_enable <= 1'b1;
            @(posedge i_clock) i_pol <= 1'b1;
            @(posedge i_clock) i_pol <= 1'b0;
            pulse_read;
            `CHK(o_flag, 1'b0)
            slave_byte(8'hA5, 8'h69, 1'b1);
            slave_byte(8'h3C, 8'h00, 1'b0);
        end
    endtask
    task master_xfer(input [1:0] cs, input [7:0] b, input integer exp_edges);
        integer k, n;
        reg seen, last, cs_ok;
        begin
            @(posedge i_clock) i_cs <= cs;
            i_tx_data <= b;
            i_tx_valid <= 1'b1;
            @(posedge i_clock) i_tx_valid <= 1'b0;
            n = 0;
            seen = 1'b0;
            cs_ok = 1'b0;
            last = o_sck_q;
            for (k = 0; k < 500 && !(seen && o_busy === 1'b0); k++) begin
                @(posedge i_clock) #1;
                if (o_sck_q !== last) n++;
                last = o_sck_q;
                if (o_busy === 1'b1) seen = 1'b1;
                if (o_cs_n === ~(4'h1 << cs)) cs_ok = 1'b1;
            end
            if (k == 500) begin n_errors++; print_verdict; end
            repeat (4) @(posedge i_clock);
            `CHK(n, exp_edges)
            `CHK(cs_ok, 1'b1)
            `CHK(o_cs_n, 4'hF)
            `CHK(o_flag, 1'b1)
            `CHK(o_hold, ~b)
            pulse_read;
            `CHK(o_flag, 1'b0)
        end
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock) #1;
        `CHK({o_cs_n, o_empty, o_flag}, 6'h3E)
        slave_startup;
        @(posedge i_clock) i_master <= 1'b1;
        i_pol <= 1'b1;
        i_pha <= 1'b0;
        i_div <= 32'h0202_0201;
        master_xfer(2'h0, 8'h96, 16);
        master_xfer(2'h1, 8'h5B, 18);
        i_div <= 32'h0101_0101;
        master_xfer(2'h0, 8'hC3, 16);
        print_verdict;
    end
endmodule
